// ---- rtl/iev_top.sv ----
// Purpose: Set/clear interrupt event register, bits 31 down to 22
// Assumes: All event sources and the mask word come from logic on core_clk
// Notes: The mask register lives elsewhere; its value arrives as a port
//
// The address-and-strobe port is this design's own decision.

`timescale 1ns/100ps
`default_nettype none

// How it works
// - Bits set on rising source edge, stay set
// - Set view write sets one bits
// - Only clear view one bits clear
// - Set view read returns raw events
// - Clear view read returns events AND mask
// - Bits 31, 28 reserved, read zero
// - Bit 30 on EEPROM load done
// - Bit 29 changes only by software
// - Bit 27 needs late ack enable
// - Bit 27 conditions: FIFO, response busy, tardy
// - Bit 26 on PHY register byte arrival
// - Bit 25 when cycle exceeds 125 us
// - Overlong cycle clears cycle source role
// - Bit 24 on fatal subunit halt
// - Bit 24 blocks faulting context events
// - Bit 23 on cycle start time mismatch
// - Bit 22 when cycle start missing
// - Bit 22 may be predicted early
// - Tick when local cycle count LSB toggles
module iev_top
#(
    parameter int LONG_CYCLES = iev_pkg::LONG_CYCLES
)
(
    // Clock and reset
    input wire logic core_clk,
    input wire logic rst,
    input wire logic clk_en,
    // Register port
    input wire iev_pkg::iev_bus_req_t reg_req,
    output logic [31:0] reg_rdata,
    // Mask word from the mask register
    input wire logic [31:0] interrupt_mask_reg,
    // Event sources
    input wire logic eeprom_load_done,
    input wire logic late_ack_event_enable,
    input wire logic rx_fifo_pending,
    input wire logic phy_resp_busy,
    input wire logic ack_tardy_sent,
    input wire logic phy_reg_byte_rcvd,
    input wire logic subunit_halted,
    // Cycle timing
    input wire logic cycle_source_role,
    input wire logic cycle_start_tx_begin,
    input wire logic cycle_start_seen,
    input wire logic cycle_start_rx,
    input wire iev_pkg::iev_cycle_time_t rx_cycle_time,
    input wire iev_pkg::iev_cycle_time_t local_cycle_time,
    input wire logic subaction_gap_end,
    input wire logic arb_reset_gap,
    input wire logic packet_start,
    // Results
    output logic [31:0] interrupt_event_reg,
    output logic cycle_source_clear,
    output logic fatal_event_block
);

    iev_pkg::iev_top_st_t s_q;
    iev_pkg::iev_top_st_t s_d;

    logic [31:0] hw_level;
    logic [31:0] hw_rise;
    logic [31:0] sw_set;
    logic [31:0] sw_clr;
    logic cycle_tick;
    logic long_fire;
    logic miss_fire;
    logic mism_fire;
    logic set_hit;
    logic clr_hit;

    function automatic logic [31:0] impl_bits(input logic [31:0] v);
        impl_bits = v & iev_pkg::EV_IMPL_MASK;
    endfunction

    iev_edge u_edge
    (
        .core_clk(core_clk),
        .rst(rst),
        .clk_en(clk_en),
        .level_in(hw_level),
        .rise_out(hw_rise)
    );

    assign set_hit = reg_req.addr == iev_pkg::SET_VIEW_OFS;
    assign clr_hit = reg_req.addr == iev_pkg::CLR_VIEW_OFS;

    localparam logic [iev_pkg::LONG_CNT_W-1:0] LONG_CNT_MAX =
        iev_pkg::LONG_CNT_W'(LONG_CYCLES);

    // Event detection stays apart from the next-state logic: the edge detector sits
    // between the two, and one process on both sides would close a false loop
    always_comb
    begin
        cycle_tick = local_cycle_time.count[0] != s_q.tick_lsb;
        mism_fire = cycle_start_rx && (rx_cycle_time != local_cycle_time);
        // Same priority as the timer below: role loss, gap end and a restart all win
        long_fire = cycle_source_role && !subaction_gap_end && !cycle_start_tx_begin
            && s_q.long_run && (s_q.long_cnt == LONG_CNT_MAX);
        miss_fire = 1'b0;
        if (!cycle_start_seen)
        begin
            if (s_q.cl == iev_pkg::CL_WAIT_GAP)
            begin
                miss_fire = cycle_tick || arb_reset_gap;
            end
            else if (s_q.cl == iev_pkg::CL_WAIT_PKT)
            begin
                miss_fire = cycle_tick || arb_reset_gap || packet_start;
            end
        end

        // Hardware sources as levels; each rise becomes one set pulse
        hw_level = '0;
        hw_level[iev_pkg::B_EEPROM] = eeprom_load_done;
        hw_level[iev_pkg::B_LATE] = late_ack_event_enable
            && (rx_fifo_pending || phy_resp_busy || ack_tardy_sent);
        hw_level[iev_pkg::B_PHYREG] = phy_reg_byte_rcvd;
        hw_level[iev_pkg::B_LONG] = long_fire;
        hw_level[iev_pkg::B_FATAL] = subunit_halted;
        hw_level[iev_pkg::B_MISM] = mism_fire;
        hw_level[iev_pkg::B_MISS] = miss_fire;
        // Bit 29 has no hardware source and stays zero here
    end

    always_comb
    begin
        s_d = s_q;
        s_d.role_clr = 1'b0;
        s_d.rdata = iev_pkg::RDATA_RESET;
        s_d.tick_lsb = local_cycle_time.count[0];

        // Overlong cycle timer, armed only while this node sources cycles
        if (!cycle_source_role || subaction_gap_end)
        begin
            s_d.long_run = 1'b0;
        end
        else if (cycle_start_tx_begin)
        begin
            s_d.long_run = 1'b1;
            s_d.long_cnt = '0;
        end
        else if (s_q.long_run)
        begin
            if (long_fire)
            begin
                s_d.long_run = 1'b0;
                s_d.role_clr = 1'b1;
            end
            else
            begin
                s_d.long_cnt = s_q.long_cnt + 1'b1;
            end
        end

        // Missing cycle watch; reports once per cycle, predicted or late
        case (s_q.cl)
            iev_pkg::CL_IDLE:
            begin
                if (cycle_tick)
                begin
                    s_d.cl = iev_pkg::CL_WAIT_GAP;
                end
            end
            iev_pkg::CL_WAIT_GAP:
            begin
                if (cycle_start_seen)
                begin
                    s_d.cl = iev_pkg::CL_DONE;
                end
                else if (miss_fire)
                begin
                    s_d.cl = cycle_tick ? iev_pkg::CL_WAIT_GAP : iev_pkg::CL_DONE;
                end
                else if (subaction_gap_end)
                begin
                    s_d.cl = iev_pkg::CL_WAIT_PKT;
                end
            end
            iev_pkg::CL_WAIT_PKT:
            begin
                if (cycle_start_seen)
                begin
                    s_d.cl = iev_pkg::CL_DONE;
                end
                else if (miss_fire)
                begin
                    s_d.cl = cycle_tick ? iev_pkg::CL_WAIT_GAP : iev_pkg::CL_DONE;
                end
            end
            iev_pkg::CL_DONE:
            begin
                if (cycle_tick)
                begin
                    s_d.cl = iev_pkg::CL_WAIT_GAP;
                end
            end
            default:
            begin
                s_d.cl = iev_pkg::CL_IDLE;
            end
        endcase

        sw_set = (reg_req.wr && set_hit) ? reg_req.wdata : '0;
        sw_clr = (reg_req.wr && clr_hit) ? reg_req.wdata : '0;

        // Clear first, then set, so a coinciding event survives the clear
        s_d.ev = impl_bits((s_q.ev & ~sw_clr) | hw_rise | sw_set);

        if (reg_req.rd && set_hit)
        begin
            s_d.rdata = impl_bits(s_q.ev);
        end
        else if (reg_req.rd && clr_hit)
        begin
            s_d.rdata = impl_bits(s_q.ev & interrupt_mask_reg);
        end
    end

    always_ff @(posedge core_clk)
    begin
        if (rst)
        begin
            s_q.ev <= iev_pkg::EV_RESET;
            s_q.rdata <= iev_pkg::RDATA_RESET;
            s_q.long_cnt <= '0;
            s_q.long_run <= 1'b0;
            s_q.tick_lsb <= 1'b0;
            s_q.role_clr <= 1'b0;
            s_q.cl <= iev_pkg::CL_IDLE;
        end
        else if (clk_en)
        begin
            s_q <= s_d;
        end
    end

    assign reg_rdata = s_q.rdata;
    assign interrupt_event_reg = s_q.ev;
    assign cycle_source_clear = s_q.role_clr;
    // Context logic must hold back its normal events while this is high
    assign fatal_event_block = s_q.ev[iev_pkg::B_FATAL];

    // Checks

    set_wins_a: assert property (
        @(posedge core_clk) disable iff (rst)
        clk_en && reg_req.wr && clr_hit && (hw_rise != 32'h0000_0000)
        |=> (s_q.ev & $past(hw_rise)) == $past(hw_rise))
        else $error("event lost against a clear");

    rdata_idle_a: assert property (
        @(posedge core_clk) disable iff (rst)
        clk_en && !reg_req.rd
        |=> reg_rdata == 32'h0000_0000)
        else $error("read data outside its slot");

    freeze_hold_a: assert property (
        @(posedge core_clk) disable iff (rst)
        !clk_en
        |=> interrupt_event_reg == $past(interrupt_event_reg) && reg_rdata == $past(reg_rdata))
        else $error("state moved while clock enable low");

    reserved_zero_a: assert property (
        @(posedge core_clk) disable iff (rst)
        s_q.ev[31] == 1'b0 && s_q.ev[28] == 1'b0
            && reg_rdata[31] == 1'b0 && reg_rdata[28] == 1'b0)
        else $error("reserved bit nonzero");

    raw_read_a: assert property (
        @(posedge core_clk) disable iff (rst)
        clk_en && reg_req.rd && set_hit |=> reg_rdata == $past(s_q.ev))
        else $error("set view read not raw");

    masked_read_a: assert property (
        @(posedge core_clk) disable iff (rst)
        clk_en && reg_req.rd && clr_hit
        |=> reg_rdata == ($past(s_q.ev) & $past(interrupt_mask_reg)))
        else $error("clear view read not masked");

    sticky_bits_a: assert property (
        @(posedge core_clk) disable iff (rst)
        !(clk_en && reg_req.wr && clr_hit)
        |=> (s_q.ev & $past(s_q.ev)) == $past(s_q.ev))
        else $error("event bit dropped without clear");

    clear_works_a: assert property (
        @(posedge core_clk) disable iff (rst)
        clk_en && reg_req.wr && clr_hit && reg_req.wdata[iev_pkg::B_SOFT]
            && !(reg_req.wr && set_hit)
        |=> !s_q.ev[iev_pkg::B_SOFT])
        else $error("clear write left soft bit set");

    sw_set_a: assert property (
        @(posedge core_clk) disable iff (rst)
        clk_en && reg_req.wr && set_hit
        |=> (s_q.ev & impl_bits($past(reg_req.wdata))) == impl_bits($past(reg_req.wdata)))
        else $error("set write did not set");

    soft_only_a: assert property (
        @(posedge core_clk) disable iff (rst)
        $rose(s_q.ev[iev_pkg::B_SOFT])
        |-> $past(clk_en && reg_req.wr && set_hit && reg_req.wdata[iev_pkg::B_SOFT]))
        else $error("soft bit set by hardware");

    late_ack_a: assert property (
        @(posedge core_clk) disable iff (rst)
        $rose(s_q.ev[iev_pkg::B_LATE])
        |-> $past(late_ack_event_enable) || $past(reg_req.wr && set_hit))
        else $error("late ack event without enable");

    long_cycle_a: assert property (
        @(posedge core_clk) disable iff (rst)
        clk_en && long_fire
        |=> s_q.ev[iev_pkg::B_LONG] && cycle_source_clear ##1 !cycle_source_clear)
        else $error("overlong cycle not reported");

    mismatch_a: assert property (
        @(posedge core_clk) disable iff (rst)
        clk_en && cycle_start_rx && rx_cycle_time != local_cycle_time
        |=> s_q.ev[iev_pkg::B_MISM])
        else $error("cycle mismatch not reported");

    lost_cycle_a: assert property (
        @(posedge core_clk) disable iff (rst)
        clk_en && s_q.cl == iev_pkg::CL_WAIT_GAP && !cycle_start_seen
            && local_cycle_time.count[0] != s_q.tick_lsb
        |=> s_q.ev[iev_pkg::B_MISS])
        else $error("lost cycle not reported");

endmodule

`default_nettype wire

// ---- rtl/iev_pkg.sv ----
// Purpose: Shared constants and types for the upper interrupt event block
// Assumes: 32-bit register words, byte addresses on an 8-bit address bus
// Notes: Bits 21..0 of the event word belong to another block and read as zero here

package iev_pkg;

    // Register map (byte addresses)
    localparam logic [7:0] SET_VIEW_OFS = 8'h80;
    localparam logic [7:0] CLR_VIEW_OFS = 8'h84;

    // Event bit positions
    localparam int B_EEPROM = 30;
    localparam int B_SOFT = 29;
    localparam int B_LATE = 27;
    localparam int B_PHYREG = 26;
    localparam int B_LONG = 25;
    localparam int B_FATAL = 24;
    localparam int B_MISM = 23;
    localparam int B_MISS = 22;

    // Bits this block implements; reserved 31 and 28 and all bits below 22 stay zero
    localparam logic [31:0] EV_IMPL_MASK = 32'h6FC0_0000;
    localparam logic [31:0] EV_RESET = 32'h0000_0000;
    localparam logic [31:0] RDATA_RESET = 32'h0000_0000;

    // Cycle timer field widths
    localparam int SEC_W = 7;
    localparam int CNT_W = 13;

    // Overlong cycle limit
    localparam int CLK_NS = 40;
    localparam int LONG_CYCLE_NS = 125000;
    localparam int LONG_CYCLES = (LONG_CYCLE_NS + CLK_NS - 1) / CLK_NS;
    localparam int LONG_CNT_W = 12;

    typedef enum logic [1:0] {
        CL_IDLE = 2'b00,
        CL_WAIT_GAP = 2'b01,
        CL_WAIT_PKT = 2'b10,
        CL_DONE = 2'b11
    } iev_cl_state_t;

    typedef struct packed {
        logic [7:0] addr;
        logic [31:0] wdata;
        logic wr;
        logic rd;
    } iev_bus_req_t;

    typedef struct packed {
        logic [SEC_W-1:0] seconds;
        logic [CNT_W-1:0] count;
    } iev_cycle_time_t;

    typedef struct packed {
        logic [31:0] ev;
        logic [31:0] rdata;
        logic [LONG_CNT_W-1:0] long_cnt;
        logic long_run;
        logic tick_lsb;
        logic role_clr;
        iev_cl_state_t cl;
    } iev_top_st_t;

    typedef struct packed {
        logic [31:0] prev;
    } iev_edge_st_t;

endpackage

// ---- rtl/iev_edge.sv ----
// Purpose: Rising edge detector for the hardware event sources
// Assumes: Sources come from logic on core_clk, so no synchroniser is needed
// Notes: A source held high raises one pulse only

`timescale 1ns/100ps
`default_nettype none

module iev_edge
(
    // Clock and reset
    input wire logic core_clk,
    input wire logic rst,
    input wire logic clk_en,
    // Levels in, pulses out
    input wire logic [31:0] level_in,
    output logic [31:0] rise_out
);

    iev_pkg::iev_edge_st_t s_q;
    iev_pkg::iev_edge_st_t s_d;

    always_comb
    begin
        s_d.prev = level_in;
        rise_out = level_in & ~s_q.prev;
    end

    always_ff @(posedge core_clk)
    begin
        if (rst)
        begin
            s_q.prev <= 32'h0000_0000;
        end
        else if (clk_en)
        begin
            s_q <= s_d;
        end
    end

endmodule

`default_nettype wire

// ---- dv/iev_tb.sv ----
// Purpose: Self-checking bench for the upper interrupt event block
// Assumes: clk_en dropped once only; mask word and event sources driven by the bench
// Notes: LONG_CYCLES shrunk to 20 so the overlong cycle case stays short

`timescale 1ns/100ps
`default_nettype none

module tb;
    localparam int LONGC = 20;
    localparam logic [31:0] M = iev_pkg::EV_IMPL_MASK;
    localparam logic [7:0] SETA = iev_pkg::SET_VIEW_OFS;
    localparam logic [7:0] CLRA = iev_pkg::CLR_VIEW_OFS;
    logic core_clk = 1'b0;
    logic rst = 1'b1;
    logic en = 1'b1;
    iev_pkg::iev_bus_req_t req = '0;
    logic [31:0] rdata;
    logic [31:0] mask = '0;
    // 0 eeprom 1 phyreg 2 halt 3 fifo 4 busy 5 tardy 6 txbeg 7 seen 8 rx 9 gap 10 arb 11 pkt
    logic [11:0] src = '0;
    logic late_en = 1'b0;
    iev_pkg::iev_cycle_time_t rxt = '0;
    iev_pkg::iev_cycle_time_t lct = '0;
    logic role = 1'b0;
    logic [31:0] ev;
    logic role_clr;
    logic fblk;
    int mismatches = 0;
    int num_checks = 0;
    int cycles = 0;
    int clr_pulses = 0;
    logic [31:0] d;
    logic [31:0] e;
    logic [31:0] c;
    logic [31:0] r;
    logic [19:0] t;

    iev_top #(.LONG_CYCLES(LONGC)) iev_top_i (
        .core_clk(core_clk), .rst(rst), .clk_en(en), .reg_req(req), .reg_rdata(rdata),
        .interrupt_mask_reg(mask), .eeprom_load_done(src[0]), .late_ack_event_enable(late_en),
        .rx_fifo_pending(src[3]), .phy_resp_busy(src[4]), .ack_tardy_sent(src[5]),
        .phy_reg_byte_rcvd(src[1]), .subunit_halted(src[2]), .cycle_source_role(role),
        .cycle_start_tx_begin(src[6]), .cycle_start_seen(src[7]), .cycle_start_rx(src[8]),
        .rx_cycle_time(rxt), .local_cycle_time(lct), .subaction_gap_end(src[9]),
        .arb_reset_gap(src[10]), .packet_start(src[11]), .interrupt_event_reg(ev),
        .cycle_source_clear(role_clr), .fatal_event_block(fblk)
    );

    always #20 core_clk = ~core_clk;

    task automatic finish_test;
        $display("checks %0d mismatches %0d", num_checks, mismatches);
        if (mismatches == 0 && num_checks > 0)
            $display("No errors found");
        else
            $display("Errors were found");
        $finish;
    endtask

    // The role input follows the clear pulse the way link control would
    always @(posedge core_clk)
    begin
        cycles <= cycles + 1;
        if (role_clr === 1'b1)
        begin
            clr_pulses <= clr_pulses + 1;
            role <= 1'b0;
        end
        if (cycles == 5000)
        begin
            mismatches = mismatches + 1;
            finish_test();
        end
    end

    task automatic chk32(input string nm, input logic [31:0] ex, input logic [31:0] got);
        num_checks++;
        if (got !== ex)
        begin
            mismatches++;
            $display("wrong value %s expected %h seen %h", nm, ex, got);
        end
    endtask

    task automatic chk1(input string nm, input logic ex, input logic got);
        num_checks++;
        if (got !== ex)
        begin
            mismatches++;
            $display("wrong value %s expected %b seen %b", nm, ex, got);
        end
    endtask

    function automatic int sbit(input int k);
        case (k)
            0: return 30;
            1: return 26;
            2: return 24;
            default: return 27;
        endcase
    endfunction

    task automatic wt(input int n);
        repeat (n) @(posedge core_clk);
    endtask

    task automatic wr(input logic [7:0] a, input logic [31:0] v);
        @(posedge core_clk);
        req <= '{addr: a, wdata: v, wr: 1'b1, rd: 1'b0};
        @(posedge core_clk);
        req.wr <= 1'b0;
    endtask

    task automatic rd(input logic [7:0] a, output logic [31:0] v);
        @(posedge core_clk);
        req <= '{addr: a, wdata: '0, wr: 1'b0, rd: 1'b1};
        @(posedge core_clk);
        req.rd <= 1'b0;
        @(negedge core_clk);
        v = rdata;
    endtask

    task automatic chk_ev(input logic [31:0] ex);
        @(negedge core_clk);
        chk32("event word", ex, ev);
    endtask

    task automatic pulse(input int k);
        @(posedge core_clk);
        src[k] <= 1'b1;
        @(posedge core_clk);
        src[k] <= 1'b0;
    endtask

    task automatic tick;
        @(posedge core_clk);
        lct.count[0] <= ~lct.count[0];
    endtask

    initial
    begin
        void'($urandom(32'hbec9));
        wt(4);
        rst <= 1'b0;
        chk_ev(32'h0);
        rd(SETA, r);
        chk32("set view", 32'h0, r);
        e = '0;
        for (int i = 0; i < 6; i++)
        begin
            d = (i == 0) ? 32'hFFFF_FFFF : $urandom();
            wr(SETA, d);
            e = e | (d & M);
            chk_ev(e);
            rd(SETA, r);
            chk32("set view", e, r);
            @(posedge core_clk);
            mask <= $urandom();
            rd(CLRA, r);
            chk32("clear view", e & mask, r);
            c = $urandom();
            wr(CLRA, c);
            e = e & ~c;
            chk_ev(e);
            wr(8'h88, 32'hFFFF_FFFF);
            rd(8'h88, r);
            chk32("unmapped read", 32'h0, r);
            chk_ev(e);
        end
        wr(CLRA, 32'hFFFF_FFFF);
        en <= 1'b0;
        wr(SETA, 32'hFFFF_FFFF);
        chk_ev(32'h0);
        @(posedge core_clk);
        en <= 1'b1;
        chk_ev(32'h0);
        $display("test register views done");
        // Index 6 repeats the FIFO source with the late ack enable low
        for (int k = 0; k < 7; k++)
        begin
            @(posedge core_clk);
            late_en <= (k != 6);
            src[(k == 6) ? 3 : k] <= 1'b1;
            wt(3);
            chk_ev((k == 6) ? 32'h0 : 32'h1 << sbit(k));
            if (k == 2)
                chk1("fatal block", 1'b1, fblk);
            wr(CLRA, 32'hFFFF_FFFF);
            wt(3);
            chk_ev(32'h0);
            chk1("fatal block", 1'b0, fblk);
            @(posedge core_clk);
            src[(k == 6) ? 3 : k] <= 1'b0;
        end
        // Source edge lands together with a clear of the same bit
        @(posedge core_clk);
        src[1] <= 1'b1;
        req <= '{addr: CLRA, wdata: 32'hFFFF_FFFF, wr: 1'b1, rd: 1'b0};
        @(posedge core_clk);
        req.wr <= 1'b0;
        wt(3);
        chk_ev(32'h1 << 26);
        @(posedge core_clk);
        src[1] <= 1'b0;
        wr(CLRA, 32'hFFFF_FFFF);
        $display("test event sources done");
        for (int k = 0; k < 3; k++)
        begin
            @(posedge core_clk);
            t = 20'($urandom()) & 20'hFFFFE;
            lct <= t;
            rxt <= t ^ ((k == 0) ? 20'h0 : (k == 1) ? 20'h02000 : 20'h00020);
            pulse(8);
            wt(2);
            chk_ev((k == 0) ? 32'h0 : 32'h1 << 23);
            wr(CLRA, 32'hFFFF_FFFF);
        end
        $display("test cycle mismatch done");
        @(posedge core_clk);
        role <= 1'b1;
        pulse(6);
        wt(LONGC);
        chk_ev(32'h0);
        wt(1);
        chk_ev(32'h1 << 25);
        chk1("role clear", 1'b1, role_clr);
        wt(1);
        @(negedge core_clk);
        chk1("role clear", 1'b0, role_clr);
        chk32("role clear pulses", 32'h1, 32'(clr_pulses));
        wr(CLRA, 32'hFFFF_FFFF);
        @(posedge core_clk);
        role <= 1'b1;
        pulse(6);
        wt(5);
        pulse(9);
        wt(LONGC + 10);
        chk_ev(32'h0);
        chk32("role clear pulses", 32'h1, 32'(clr_pulses));
        $display("test overlong cycle done");
        tick();
        wt(4);
        tick();
        wt(3);
        chk_ev(32'h1 << 22);
        wr(CLRA, 32'hFFFF_FFFF);
        pulse(7);
        tick();
        pulse(7);
        wt(3);
        tick();
        wt(3);
        chk_ev(32'h0);
        pulse(10);
        wt(3);
        chk_ev(32'h1 << 22);
        wr(CLRA, 32'hFFFF_FFFF);
        tick();
        pulse(9);
        pulse(11);
        wt(3);
        chk_ev(32'h1 << 22);
        $display("test missing cycle done");
        finish_test();
    end
endmodule

`default_nettype wire
